// >>> core/psc_page_stack.sv
/*
 * Three-byte register page context stack with software access.
 * Assumes the core gives one-cycle entry and return pulses on sys_clk,
 * and single-cycle read and write strobes on the register port.
 */
`timescale 1ns/1ps

module psc_page_stack
#(
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire psc_pkg::psc_sfr_req_t sfr_req,
    output logic [DATA_W-1:0]          sfr_rdata,
    // Core interrupt sequencing
    input  wire psc_pkg::psc_irq_evt_t irq_evt,
    // Current page to the register decode of the core
    output logic [DATA_W-1:0]          active_register_page
);

    // Elaboration check: the stack bytes are exactly one register wide
    if (DATA_W != 8)
    begin : g_width_check
        $error("psc_page_stack supports DATA_W of 8 only");
    end

    logic [psc_pkg::STACK_DEPTH-1:0] hit;
    logic                            push;
    logic                            pop;
    logic [DATA_W-1:0]               active_ff;
    logic [DATA_W-1:0]               second_ff;
    logic [DATA_W-1:0]               third_ff;
    logic [DATA_W-1:0]               rdata_ff;
    logic [DATA_W-1:0]               nxt_active;
    logic [DATA_W-1:0]               nxt_second;
    logic [DATA_W-1:0]               nxt_third;
    logic [DATA_W-1:0]               nxt_rdata;

    // Address decode
    psc_sfr_decode u_decode
    (
        .addr (sfr_req.addr),
        .hit  (hit)
    );

    // Entry wins over a same-cycle return: the new handler must be saved
    assign push = irq_evt.entry;
    assign pop  = irq_evt.ret & ~irq_evt.entry;

    // Stack next state; a stack move takes the cycle, a colliding write is lost
    always_comb
    begin
        nxt_active = active_ff;
        nxt_second = second_ff;
        nxt_third  = third_ff;
        if (push)
        begin
            nxt_third  = second_ff;
            nxt_second = active_ff;
        end
        else if (pop)
        begin
            nxt_active = second_ff;
            nxt_second = third_ff;
        end
        else if (sfr_req.wr)
        begin
            // Each write touches only its own byte
            if (hit[psc_pkg::HIT_ACTIVE])
            begin
                nxt_active = sfr_req.wdata;
            end
            if (hit[psc_pkg::HIT_SECOND])
            begin
                nxt_second = sfr_req.wdata;
            end
            if (hit[psc_pkg::HIT_THIRD])
            begin
                nxt_third = sfr_req.wdata;
            end
        end
    end

    // Stack registers, three bytes deep
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            active_ff <= psc_pkg::RST_ACTIVE_PAGE;
            second_ff <= psc_pkg::RST_SECOND_ENTRY;
            third_ff  <= psc_pkg::RST_THIRD_ENTRY;
        end
        else
        begin
            active_ff <= nxt_active;
            second_ff <= nxt_second;
            third_ff  <= nxt_third;
        end
    end

    // Read data; reads have no effect on the stack
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (sfr_req.rd)
        begin
            if (hit[psc_pkg::HIT_SECOND])
            begin
                nxt_rdata = second_ff;
            end
            else if (hit[psc_pkg::HIT_ACTIVE])
            begin
                nxt_rdata = active_ff;
            end
            else if (hit[psc_pkg::HIT_THIRD])
            begin
                nxt_rdata = third_ff;
            end
            else
            begin
                nxt_rdata = psc_pkg::RDATA_UNMAPPED;
            end
        end
    end

    // Read data register holds until the next read
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rdata_ff <= psc_pkg::RDATA_UNMAPPED;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata            = rdata_ff;
    assign active_register_page = active_ff;

    // Checks on the stack behaviour
    a_push_shift_down: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        irq_evt.entry |=> (third_ff == $past(second_ff)) && (second_ff == $past(active_ff))
    ) else $error("push did not shift the stack");

    a_pop_load_page: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (irq_evt.ret && !irq_evt.entry) |=> active_register_page == $past(second_ff)
    ) else $error("return did not load active page from second entry");

    a_pop_shift_up: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (irq_evt.ret && !irq_evt.entry) |=> second_ff == $past(third_ff)
    ) else $error("return did not move third entry into second");

    a_stack_idle_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!irq_evt.entry && !irq_evt.ret && !sfr_req.wr)
        |=> $stable(active_ff) && $stable(second_ff) && $stable(third_ff)
    ) else $error("stack changed without an interrupt event or write");

    a_write_second_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.wr && sfr_req.addr == psc_pkg::ADDR_SECOND_ENTRY && !irq_evt.entry && !irq_evt.ret)
        |=> second_ff == $past(sfr_req.wdata)
    ) else $error("write did not update second entry");

    a_write_no_move: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.wr && sfr_req.addr == psc_pkg::ADDR_SECOND_ENTRY && !irq_evt.entry && !irq_evt.ret)
        |=> $stable(active_ff) && $stable(third_ff)
    ) else $error("write to second entry disturbed other bytes");

    a_read_second_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.rd && sfr_req.addr == psc_pkg::ADDR_SECOND_ENTRY)
        |=> sfr_rdata == $past(second_ff)
    ) else $error("read of second entry returned wrong value");

    a_reset_second_zero: assert property (
        @(posedge sys_clk)
        sys_rst |=> second_ff == psc_pkg::RST_SECOND_ENTRY
    ) else $error("second entry not zero after reset");

    a_push_pop_restore: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (irq_evt.entry ##1 (irq_evt.ret && !irq_evt.entry)) |=> active_ff == $past(active_ff, 2)
    ) else $error("entry then return did not restore the page");

    a_push_keep_active: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        irq_evt.entry |=> $stable(active_ff)
    ) else $error("entry changed the active page");

    a_pop_keep_third: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (irq_evt.ret && !irq_evt.entry) |=> $stable(third_ff)
    ) else $error("return changed the third entry");

    a_write_third_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.wr && sfr_req.addr == psc_pkg::ADDR_THIRD_ENTRY && !irq_evt.entry && !irq_evt.ret)
        |=> (third_ff == $past(sfr_req.wdata)) && $stable(active_ff) && $stable(second_ff)
    ) else $error("write to third entry went astray");

    a_write_active_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.wr && sfr_req.addr == psc_pkg::ADDR_ACTIVE_PAGE && !irq_evt.entry && !irq_evt.ret)
        |=> (active_ff == $past(sfr_req.wdata)) && $stable(second_ff) && $stable(third_ff)
    ) else $error("write to active page went astray");

    a_read_third_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.rd && sfr_req.addr == psc_pkg::ADDR_THIRD_ENTRY)
        |=> sfr_rdata == $past(third_ff)
    ) else $error("read of third entry returned wrong value");

    a_read_active_byte: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.rd && sfr_req.addr == psc_pkg::ADDR_ACTIVE_PAGE)
        |=> sfr_rdata == $past(active_ff)
    ) else $error("read of active page returned wrong value");

    // Only the three stack addresses answer; anything else reads as zero
    a_read_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sfr_req.rd && sfr_req.addr != psc_pkg::ADDR_ACTIVE_PAGE
            && sfr_req.addr != psc_pkg::ADDR_SECOND_ENTRY && sfr_req.addr != psc_pkg::ADDR_THIRD_ENTRY)
        |=> sfr_rdata == psc_pkg::RDATA_UNMAPPED
    ) else $error("read of unmapped address returned data");

    a_rdata_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !sfr_req.rd |=> $stable(sfr_rdata)
    ) else $error("read data changed without a read");

endmodule

// >>> core/psc_pkg.sv
/*
 * Constants and carrier types for the page context stack.
 * Assumes an 8-bit special-function-register space and one core clock.
 */
// Notes on behaviour
// - Page context is three bytes: active page, second entry, third entry.
// - Software access to a stack byte changes that byte only, never moves it.
// - Writing the second-entry register replaces the second stack byte.
// - Reading the second-entry register returns the second byte, no side effect.
// - Interrupt return loads the active page from the second entry.
// - Second entry is 8-bit RW at 0x85 on every page, resets to zero.
package psc_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_SECOND_ENTRY = 8'h85;
    localparam logic [7:0] ADDR_ACTIVE_PAGE  = 8'h86;
    localparam logic [7:0] ADDR_THIRD_ENTRY  = 8'h87;

    // Reset values
    localparam logic [7:0] RST_ACTIVE_PAGE   = 8'h00;
    localparam logic [7:0] RST_SECOND_ENTRY  = 8'h00;
    localparam logic [7:0] RST_THIRD_ENTRY   = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED    = 8'h00;

    // Stack depth
    localparam int STACK_DEPTH = 3;

    // Decode hit vector positions
    localparam int HIT_ACTIVE = 0;
    localparam int HIT_SECOND = 1;
    localparam int HIT_THIRD  = 2;

    // Software access carrier
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } psc_sfr_req_t;

    // Core sequencing carrier
    typedef struct packed {
        logic entry;
        logic ret;
    } psc_irq_evt_t;

endpackage

// >>> core/psc_sfr_decode.sv
/*
 * Address decoder for the three stack bytes.
 * Assumes the address is presented synchronous to the core clock.
 */
`timescale 1ns/1ps

module psc_sfr_decode
(
    // Address in
    input  wire logic [7:0]                      addr,
    // One-hot hit out, one bit per stack byte
    output logic      [psc_pkg::STACK_DEPTH-1:0] hit
);

    // Page never enters decode, so the stack bytes answer on every page
    always_comb
    begin
        hit                      = '0;
        hit[psc_pkg::HIT_ACTIVE] = (addr == psc_pkg::ADDR_ACTIVE_PAGE);
        hit[psc_pkg::HIT_SECOND] = (addr == psc_pkg::ADDR_SECOND_ENTRY);
        hit[psc_pkg::HIT_THIRD]  = (addr == psc_pkg::ADDR_THIRD_ENTRY);
    end

endmodule

// >>> verif/psc_core_model.sv
/*
 * Core interrupt sequencing model: drives entry and return pulses.
 * Assumes the bench calls pulse just after a rising edge of sys_clk.
 */
`timescale 1ns/1ps

module psc_core_model
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // Events to the stack
    output psc_pkg::psc_irq_evt_t irq_evt
);
    int depth = 0;

    initial irq_evt = '0;

    // A real core never returns without a taken entry
    task automatic pulse(input logic e, input logic r);
        irq_evt.entry = e;
        irq_evt.ret   = r && depth > 0;
    endtask

    // Nesting count; entry wins when both are raised
    always @(posedge sys_clk)
        if (sys_rst)
            depth <= 0;
        else if (irq_evt.entry)
            depth <= depth + 1;
        else if (irq_evt.ret)
            depth <= depth - 1;
endmodule

// >>> verif/psc_page_stack_tb.sv
/*
 * Self-checking bench for the page context stack.
 * Assumes the core model in psc_core_model.sv and the package psc_pkg.
 */
`timescale 1ns/1ps

module psc_page_stack_tb;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    psc_pkg::psc_sfr_req_t sfr_req = '0;
    psc_pkg::psc_irq_evt_t irq_evt;
    logic [7:0]            sfr_rdata;
    logic [7:0]            active_register_page;
    logic [7:0]            s [3];
    logic [7:0]            exp_q [$];
    logic [31:0]           v;
    int                    n_mismatch = 0;
    int                    checked = 0;
    int                    depth = 0;

    // Clock
    always #5 sys_clk = ~sys_clk;

    psc_page_stack #(.DATA_W(8)) psc_page_stack_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .irq_evt(irq_evt), .active_register_page(active_register_page));
    psc_core_model psc_core_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_evt(irq_evt));

    // Byte compare
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // One cycle of access and events; reference updated as the edge will
    task automatic cyc(input logic wr, rd, input logic [7:0] a, d, input logic e, r);
        int i;
        r = r && depth > 0;
        i = (a == psc_pkg::ADDR_SECOND_ENTRY) ? 1 : (a == psc_pkg::ADDR_ACTIVE_PAGE) ? 0 :
            (a == psc_pkg::ADDR_THIRD_ENTRY) ? 2 : 3;
        sfr_req = '{addr: a, wr: wr, rd: rd, wdata: d};
        psc_core_model_i.pulse(e, r);
        if (rd)
            exp_q.push_back(i < 3 ? s[i] : psc_pkg::RDATA_UNMAPPED);
        if (e)
        begin
            s[2] = s[1];
            s[1] = s[0];
            depth++;
        end
        else if (r)
        begin
            s[0] = s[1];
            s[1] = s[2];
            depth--;
        end
        else if (wr && i < 3)
            s[i] = d;
        @(posedge sys_clk);
        #1;
    endtask

    // Read back all three bytes and one unmapped place
    task automatic read_all();
        for (int a = 'h85; a < 'h89; a++)
            cyc(1'b0, 1'b1, a[7:0], 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        chk("active", s[0], active_register_page);
    endtask

    // Result watcher: oldest note against read data
    always @(posedge sys_clk)
        if (sfr_req.rd && !sys_rst)
        begin
            #2;
            chk("rdata", exp_q.pop_front(), sfr_rdata);
        end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles of the run
    initial
    begin
        #100000;
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h9450));
        s = '{psc_pkg::RST_ACTIVE_PAGE, psc_pkg::RST_SECOND_ENTRY, psc_pkg::RST_THIRD_ENTRY};
        repeat (5) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        @(posedge sys_clk);
        #1;
        read_all();
        $display("test reset done");
        cyc(1'b1, 1'b0, psc_pkg::ADDR_ACTIVE_PAGE, 8'h3c, 1'b0, 1'b0);
        cyc(1'b1, 1'b0, psc_pkg::ADDR_SECOND_ENTRY, 8'ha5, 1'b0, 1'b0);
        cyc(1'b1, 1'b0, psc_pkg::ADDR_THIRD_ENTRY, 8'h5a, 1'b0, 1'b0);
        cyc(1'b1, 1'b1, psc_pkg::ADDR_SECOND_ENTRY, 8'h11, 1'b1, 1'b0);
        cyc(1'b1, 1'b0, psc_pkg::ADDR_SECOND_ENTRY, 8'hc3, 1'b0, 1'b0);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
        read_all();
        $display("test context done");
        repeat (400)
        begin
            v = $urandom;
            cyc(v[0], v[1], 8'h85 + {6'h00, v[3:2]}, v[15:8], v[6:4] == 0, v[6:4] < 3);
        end
        read_all();
        $display("test random done");
        // Reset in mid-run: a loaded stack must fall back to its reset bytes
        sys_rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        s = '{psc_pkg::RST_ACTIVE_PAGE, psc_pkg::RST_SECOND_ENTRY, psc_pkg::RST_THIRD_ENTRY};
        depth = 0;
        @(posedge sys_clk);
        #1;
        read_all();
        $display("test reset again done");
        test_done();
    end
endmodule
